// ### inc/periph_irq_pkg.sv
/*
  Constants for the peripheral interrupt flag and enable block:
  APB byte offsets, field positions, widths and reset values.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
package periph_irq_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned EN1_W = 8;
  localparam int unsigned FLAG2_W = 5;
  localparam int unsigned STAT_W = 5;

  // Register byte offsets
  localparam logic [7:0] OFS_FLAG2 = 8'h00;
  localparam logic [7:0] OFS_EN1 = 8'h04;
  localparam logic [7:0] OFS_EN2 = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_PEND = 8'h18;

  // Second flag register fields
  localparam int unsigned F2_CAPCOMP2 = 0;
  localparam int unsigned F2_TIMER3 = 1;
  localparam int unsigned F2_LOW_VOLT = 2;
  localparam int unsigned F2_BUS_COLL = 3;
  localparam int unsigned F2_MEM_WRITE = 4;

  // First enable register fields
  localparam int unsigned E1_TIMER1_OVF = 0;
  localparam int unsigned E1_TIMER2_MATCH = 1;
  localparam int unsigned E1_CAPCOMP1 = 2;
  localparam int unsigned E1_SYNC_SERIAL = 3;
  localparam int unsigned E1_SERIAL_TX = 4;
  localparam int unsigned E1_SERIAL_RX = 5;
  localparam int unsigned E1_CONVERTER = 6;
  localparam int unsigned E1_PARALLEL = 7;

  // Control register fields
  localparam int unsigned CTRL_PRIO_EN = 0;
  localparam int unsigned CTRL_GLOBAL_EN = 1;

  // Pending register layout: first group low, second group above
  localparam int unsigned PEND2_LSB = 8;

  // Reset values
  localparam logic [7:0] RST_EN1 = 8'h00;
  localparam logic [4:0] RST_FLAG2 = 5'h00;
  localparam logic [4:0] RST_EN2 = 5'h00;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [4:0] RST_STAT = 5'h00;
  localparam logic [4:0] RST_MASK = 5'h00;

endpackage : periph_irq_pkg

// ### hw/periph_irq_flag_enable.sv
/*
  Peripheral interrupt flag and enable logic with an APB register slave.
  Holds the second peripheral flag register, both peripheral enable
  registers, a control register, an event status/mask pair and the
  gated request toward the core.
  Assumes: event inputs and the first-group flags come from logic on
  CLK_SYS; events are one-cycle pulses; APB master obeys APB3 timing.
*/
// The APB register port and the address map were left to the implementer.
module periph_irq_flag_enable (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [periph_irq_pkg::ADDR_W-1:0] PADDR,
  input wire logic [periph_irq_pkg::DATA_W-1:0] PWDATA,
  output logic [periph_irq_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [periph_irq_pkg::EN1_W-1:0] FLAGS1,
  input wire logic EVT_MEM_WRITE_DONE,
  input wire logic EVT_BUS_COLLISION,
  input wire logic EVT_LOW_VOLTAGE,
  input wire logic EVT_TIMER3_OVERFLOW,
  input wire logic EVT_CAPCOMP2,
  input wire logic CAPCOMP2_PWM_MODE,
  output logic [periph_irq_pkg::EN1_W-1:0] PEND1,
  output logic [periph_irq_pkg::FLAG2_W-1:0] PEND2,
  output logic [periph_irq_pkg::FLAG2_W-1:0] FLAG2,
  output logic PERIPH_IRQ,
  output logic IRQ
);
  import periph_irq_pkg::*;

  logic [FLAG2_W-1:0] flag2_q;
  logic [FLAG2_W-1:0] flag2_d;
  logic [EN1_W-1:0] en1_q;
  logic [FLAG2_W-1:0] en2_q;
  logic [1:0] ctrl_q;
  logic [STAT_W-1:0] stat_q;
  logic [STAT_W-1:0] stat_d;
  logic [STAT_W-1:0] mask_q;
  logic [FLAG2_W-1:0] evt;
  logic [DATA_W-1:0] rd_d;
  logic rd_err_d;
  logic setup;
  logic access;
  logic wr_en;
  logic rd_en;
  logic [EN1_W-1:0] pend1_d;
  logic [FLAG2_W-1:0] pend2_d;
  logic gate_ok;

  // APB phases: answer comes in the first access cycle
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && PREADY;
  assign wr_en = access && PWRITE && !PSLVERR;
  assign rd_en = access && !PWRITE && !PSLVERR;

  // Event vector; capture/compare 2 events ignored in PWM mode
  assign evt[F2_MEM_WRITE] = EVT_MEM_WRITE_DONE;
  assign evt[F2_BUS_COLL] = EVT_BUS_COLLISION;
  assign evt[F2_LOW_VOLT] = EVT_LOW_VOLTAGE;
  assign evt[F2_TIMER3] = EVT_TIMER3_OVERFLOW;
  assign evt[F2_CAPCOMP2] = EVT_CAPCOMP2 && !CAPCOMP2_PWM_MODE;

  // Read mux, sampled in the setup cycle
  always_comb begin
    rd_d = '0;
    rd_err_d = 1'b0;
    case (PADDR)
      OFS_FLAG2: rd_d[FLAG2_W-1:0] = flag2_q;
      OFS_EN1: rd_d[EN1_W-1:0] = en1_q;
      OFS_EN2: rd_d[FLAG2_W-1:0] = en2_q;
      OFS_CTRL: rd_d[1:0] = ctrl_q;
      OFS_STAT: rd_d[STAT_W-1:0] = stat_q;
      OFS_MASK: rd_d[STAT_W-1:0] = mask_q;
      OFS_PEND: begin
        rd_d[EN1_W-1:0] = PEND1;
        rd_d[PEND2_LSB +: FLAG2_W] = PEND2;
      end
      default: rd_err_d = 1'b1;
    endcase
  end

  // Bus response registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
    end else begin
      PREADY <= setup;
      if (setup) begin
        PSLVERR <= rd_err_d;
        PRDATA <= PWRITE ? '0 : rd_d;
      end else if (access) begin
        PSLVERR <= 1'b0;
        PRDATA <= '0;
      end
    end
  end

  // Flag register 2: per-bit sticky flags, set wins over software write
  generate
    for (genvar i = 0; i < FLAG2_W; i++) begin : g_flag2
      always_comb begin
        flag2_d[i] = flag2_q[i];
        if (wr_en && PADDR == OFS_FLAG2) begin
          flag2_d[i] = PWDATA[i];
        end
        if (evt[i]) begin
          flag2_d[i] = 1'b1;
        end
      end
    end
  endgenerate

  // Bits 31..5 are not stored, so writes there have no effect
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      flag2_q <= RST_FLAG2;
    end else begin
      flag2_q <= flag2_d;
    end
  end

  // Enable, control and mask registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      en1_q <= RST_EN1;
      en2_q <= RST_EN2;
      ctrl_q <= RST_CTRL;
      mask_q <= RST_MASK;
    end else if (wr_en) begin
      case (PADDR)
        OFS_EN1: en1_q <= PWDATA[EN1_W-1:0];
        OFS_EN2: en2_q <= PWDATA[FLAG2_W-1:0];
        OFS_CTRL: ctrl_q <= PWDATA[1:0];
        OFS_MASK: mask_q <= PWDATA[STAT_W-1:0];
        default: ;
      endcase
    end
  end

  // Event status: read clears only what was returned; new events win
  always_comb begin
    stat_d = stat_q;
    if (rd_en && PADDR == OFS_STAT) begin
      stat_d = stat_q & ~PRDATA[STAT_W-1:0];
    end
    stat_d = stat_d | evt;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      stat_q <= RST_STAT;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Per-source gating by the individual enable bits
  assign pend1_d = FLAGS1 & en1_q;
  assign pend2_d = flag2_q & en2_q;

  // Core request: global enable needed while the priority scheme is off
  assign gate_ok = ctrl_q[CTRL_PRIO_EN] || ctrl_q[CTRL_GLOBAL_EN];

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PEND1 <= '0;
      PEND2 <= '0;
      FLAG2 <= '0;
      PERIPH_IRQ <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      PEND1 <= pend1_d;
      PEND2 <= pend2_d;
      FLAG2 <= flag2_q;
      PERIPH_IRQ <= gate_ok && ((|pend1_d) || (|pend2_d));
      IRQ <= |(stat_q & mask_q);
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  sequence s_flag2_read;
    PSEL && PENABLE && PREADY && !PWRITE && PADDR == OFS_FLAG2;
  endsequence

  sequence s_no_flag2_write;
    !(PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_FLAG2);
  endsequence

  sequence s_setup;
    PSEL && !PENABLE;
  endsequence

  sequence s_any_write;
    PSEL && PENABLE && PREADY && PWRITE;
  endsequence

  sequence s_bad_write;
    PSEL && PENABLE && PREADY && PWRITE && PSLVERR;
  endsequence

  sequence s_en1_write;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_EN1;
  endsequence

  sequence s_en2_write;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_EN2;
  endsequence

  sequence s_stat_read;
    PSEL && PENABLE && PREADY && !PWRITE && PADDR == OFS_STAT;
  endsequence

  sequence s_pend_read;
    PSEL && PENABLE && PREADY && !PWRITE && PADDR == OFS_PEND;
  endsequence

  a_flag2_upper_zero: assert property (
    s_flag2_read |-> PRDATA[DATA_W-1:FLAG2_W] == '0)
    else $error("flag register 2 upper bits not zero");

  a_flag2_write_mask: assert property (
    (PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_FLAG2
     && evt == '0) |=> flag2_q == $past(PWDATA[FLAG2_W-1:0]))
    else $error("flag register 2 write not stored as low bits");

  a_global_gate_off: assert property (
    (!ctrl_q[CTRL_PRIO_EN] && !ctrl_q[CTRL_GLOBAL_EN])[*2]
    |-> !PERIPH_IRQ)
    else $error("peripheral request passed with global enable off");

  a_request_reaches: assert property (
    (ctrl_q[CTRL_GLOBAL_EN] && (|(FLAGS1 & en1_q))) |=> PERIPH_IRQ)
    else $error("enabled request did not reach the core");

  a_timer2_gate: assert property (
    !en1_q[E1_TIMER2_MATCH] |=> !PEND1[E1_TIMER2_MATCH])
    else $error("timer two match passed while disabled");

  a_enable_pass: assert property (
    (en1_q[E1_TIMER1_OVF] && FLAGS1[E1_TIMER1_OVF]) ##1
    (en1_q[E1_PARALLEL] && FLAGS1[E1_PARALLEL])
    |-> PEND1[E1_TIMER1_OVF] ##1 PEND1[E1_PARALLEL])
    else $error("enabled source blocked");

  a_group1_order: assert property (
    PEND1 == $past(FLAGS1 & en1_q))
    else $error("first group gating out of order");

  a_flag2_sticky: assert property (
    s_no_flag2_write |=> (flag2_q & $past(flag2_q)) == $past(flag2_q))
    else $error("flag register 2 bit lost without software clear");

  a_event_sets: assert property (
    EVT_BUS_COLLISION |=> flag2_q[F2_BUS_COLL] ##1 FLAG2[F2_BUS_COLL])
    else $error("bus collision event did not set its flag");

  a_pwm_ignored: assert property (
    ((EVT_CAPCOMP2 && CAPCOMP2_PWM_MODE && !flag2_q[F2_CAPCOMP2])
     and s_no_flag2_write) |=> !flag2_q[F2_CAPCOMP2])
    else $error("capture/compare 2 flag set in PWM mode");

  a_irq_level: assert property (
    (|(stat_q & mask_q)) |=> IRQ)
    else $error("interrupt output low with unmasked status");

  a_irq_quiet: assert property (
    !(|(stat_q & mask_q)) |=> !IRQ)
    else $error("interrupt output high with nothing unmasked");

  a_ready_after_setup: assert property (
    s_setup |=> PREADY)
    else $error("no ready in the first access cycle");

  a_ready_pulse: assert property (
    PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");

  a_slverr_ready: assert property (
    PSLVERR |-> PREADY)
    else $error("error response without ready");

  a_write_rdata_zero: assert property (
    s_any_write |-> PRDATA == '0)
    else $error("read data not zero during a write");

  a_error_no_write: assert property (
    s_bad_write |=> $stable(en1_q) && $stable(en2_q)
    && $stable(ctrl_q) && $stable(mask_q))
    else $error("refused write changed a register");

  a_en1_write: assert property (
    s_en1_write |=> en1_q == $past(PWDATA[EN1_W-1:0]))
    else $error("enable register 1 write not stored");

  a_en2_write: assert property (
    s_en2_write |=> en2_q == $past(PWDATA[FLAG2_W-1:0]))
    else $error("enable register 2 write not stored");

  a_stat_read_clear: assert property (
    s_stat_read |=> stat_q == (($past(stat_q)
    & ~$past(PRDATA[STAT_W-1:0])) | $past(evt)))
    else $error("status read did not clear returned bits");

  a_pend_read: assert property (
    s_pend_read |-> PRDATA[EN1_W-1:0] == $past(PEND1)
    && PRDATA[PEND2_LSB +: FLAG2_W] == $past(PEND2))
    else $error("pending register read mismatch");

  a_group2_order: assert property (
    PEND2 == $past(flag2_q & en2_q))
    else $error("second group gating wrong");

  a_flag2_copy: assert property (
    FLAG2 == $past(flag2_q))
    else $error("flag register 2 output copy wrong");

  a_event_flags: assert property (
    (|evt) |=> (flag2_q & $past(evt)) == $past(evt))
    else $error("event did not set its flag");

  a_event_status: assert property (
    (|evt) |=> (stat_q & $past(evt)) == $past(evt))
    else $error("event did not set its status bit");

  a_pwm_no_event: assert property (
    (EVT_CAPCOMP2 && CAPCOMP2_PWM_MODE) |-> !evt[F2_CAPCOMP2])
    else $error("capture/compare 2 event passed in PWM mode");

  a_prio_bypass: assert property (
    (ctrl_q[CTRL_PRIO_EN] && (|(FLAGS1 & en1_q))) |=> PERIPH_IRQ)
    else $error("request blocked with priority scheme on");

  a_no_pend_quiet: assert property (
    (!(|(FLAGS1 & en1_q)) && !(|(flag2_q & en2_q))) |=> !PERIPH_IRQ)
    else $error("request raised with no enabled source");

  a_timer2_pass: assert property (
    (en1_q[E1_TIMER2_MATCH] && FLAGS1[E1_TIMER2_MATCH])
    |=> PEND1[E1_TIMER2_MATCH])
    else $error("timer two match blocked while enabled");

endmodule : periph_irq_flag_enable

// ### tb/periph_src_model.sv
/*
  Peripheral event source model: one-cycle event pulses and a sticky
  first-group flag register. Assumes requests arrive on rising edges.
*/
module periph_src_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] fire,
  input wire logic [7:0] set1,
  input wire logic [7:0] clr1,
  output logic [4:0] evt,
  output logic [7:0] flags1
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk) begin
    if (rst) evt <= '0;
    else evt <= fire & ~evt; // One-cycle event pulses
  end
  always_ff @(posedge clk) begin
    if (rst) flags1 <= '0;
    else flags1 <= (flags1 & ~clr1) | set1; // Held until cleared
  end
endmodule : periph_src_model

// ### tb/peripheral_irq_flag_enable_tb_top.sv
/*
  Self-checking bench for the peripheral interrupt flag and enable block.
  Assumes the APB offsets and field order of the package.
*/
module peripheral_irq_flag_enable_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import periph_irq_pkg::*;
  logic clk_sys, rst, psel, penable, pwrite, pwm, pready, pslverr;
  logic irq, pirq, err;
  logic [7:0] paddr, set1, clr1, flags1, pend1;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] fire, evt, flag2, pend2;
  int errors, checks;
  periph_src_model u_periph_src_model (.clk(clk_sys), .rst(rst),
    .fire(fire), .set1(set1), .clr1(clr1), .evt(evt), .flags1(flags1));
  periph_irq_flag_enable u_periph_irq_flag_enable (.CLK_SYS(clk_sys),
    .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FLAGS1(flags1), .EVT_MEM_WRITE_DONE(evt[4]),
    .EVT_BUS_COLLISION(evt[3]), .EVT_LOW_VOLTAGE(evt[2]),
    .EVT_TIMER3_OVERFLOW(evt[1]), .EVT_CAPCOMP2(evt[0]),
    .CAPCOMP2_PWM_MODE(pwm), .PEND1(pend1), .PEND2(pend2), .FLAG2(flag2),
    .PERIPH_IRQ(pirq), .IRQ(irq));
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask : apb
  task automatic t_regs;
    apb(0, OFS_EN1, 0);
    chk("en1 reset", 32'h0, rd);
    apb(1, OFS_FLAG2, 32'hFFFFFFFF);
    apb(0, OFS_FLAG2, 0);
    chk("flag2 upper", 32'h1F, rd);
    apb(1, OFS_FLAG2, 0);
    apb(1, OFS_EN1, 32'hA5);
    apb(0, OFS_EN1, 0);
    chk("en1 rw", 32'hA5, rd);
    apb(1, 8'h40, 32'h1);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("test regs done");
  endtask : t_regs
  task automatic t_events;
    for (int i = 0; i < 5; i++) begin
      fire <= 5'(1 << i);
      cyc(1);
      fire <= 0;
      cyc(8);
      chk("flag2 held", 32'(1 << i), {27'h0, flag2});
      apb(1, OFS_FLAG2, 0);
      cyc(2);
      chk("flag2 clear", 32'h0, {27'h0, flag2});
    end
    pwm <= 1;
    fire <= 5'h01;
    cyc(1);
    fire <= 0;
    cyc(4);
    chk("pwm ignore", 32'h0, {27'h0, flag2});
    pwm <= 0;
    $display("test events done");
  endtask : t_events
  task automatic t_status;
    apb(1, OFS_MASK, 32'h02);
    apb(0, OFS_STAT, 0);
    fire <= 5'h01;
    cyc(1);
    fire <= 0;
    cyc(4);
    chk("irq masked", 32'h0, {31'h0, irq});
    fire <= 5'h02;
    cyc(1);
    fire <= 0;
    cyc(4);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(0, OFS_STAT, 0);
    chk("status", 32'h03, rd);
    cyc(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1, OFS_FLAG2, 32'h04);
    apb(1, OFS_EN2, 32'h04);
    cyc(2);
    chk("pend2", 32'h04, {27'h0, pend2});
    apb(0, OFS_PEND, 0);
    chk("pend reg", 32'h400, rd);
    apb(1, OFS_EN2, 0);
    $display("test status done");
  endtask : t_status
  task automatic t_gate;
    apb(1, OFS_EN1, 32'hFF);
    set1 <= 8'hFF;
    cyc(1);
    set1 <= 0;
    cyc(3);
    chk("no global", 32'h0, {31'h0, pirq});
    apb(1, OFS_CTRL, 32'h1);
    cyc(3);
    chk("prio bypass", 32'h1, {31'h0, pirq});
    apb(1, OFS_CTRL, 32'h2);
    cyc(3);
    chk("global on", 32'h1, {31'h0, pirq});
    for (int i = 0; i < 8; i++) begin
      apb(1, OFS_EN1, 32'(1 << i));
      clr1 <= 8'hFF;
      set1 <= ~8'(1 << i);
      cyc(1);
      clr1 <= 0;
      set1 <= 0;
      cyc(3);
      chk("blocked", 32'h0, {31'h0, pirq});
      set1 <= 8'(1 << i);
      cyc(4);
      chk("pend1", 32'(1 << i), {24'h0, pend1});
      chk("passed", 32'h1, {31'h0, pirq});
    end
    $display("test gate done");
  endtask : t_gate
  initial begin
    rst = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    pwm = 0;
    fire = 0;
    set1 = 0;
    clr1 = 0;
    errors = 0;
    checks = 0;
    cyc(5);
    rst <= 0;
    t_regs();
    t_events();
    t_status();
    t_gate();
    end_of_test();
  end
endmodule : peripheral_irq_flag_enable_tb_top
